// ---- logic/mfrm_pkg.sv ----
/*
 * Shared constants and carrier types of the motor fault response manager.
 * Assumes a single 100 MHz clock and APB register access.
 */
package mfrm_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 100;
  localparam int T_OC_RETRY_US   = 5000;   // Overcurrent retry time
  localparam int T_LOCK_RETRY_TIME_US  = 100000; // Lock retry time
  localparam int T_OPEN_PHASE_MS = 500;
  localparam int T_BUCK_DEG_NS   = 1000;
  localparam int OC_RETRY_CYC    = T_OC_RETRY_US * CLK_MHZ;
  localparam int LOCK_RETRY_TIME_CYC   = T_LOCK_RETRY_TIME_US * CLK_MHZ;
  localparam int OPEN_PHASE_CYC  = T_OPEN_PHASE_MS * 1000 * CLK_MHZ;
  localparam int BUCK_DEG_CYC    = (T_BUCK_DEG_NS * CLK_MHZ + 999) / 1000;
  // Supply levels in 0.1 V steps
  localparam int UV_HYST_DV      = 5;
  localparam int UV_STEP_DV      = 30;

  // ************************************************************
  // Register offsets and fields
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_THR    = 12'h008;
  localparam logic [11:0] ADDR_THR2   = 12'h00c;
  localparam logic [11:0] ADDR_DEG    = 12'h010;
  localparam int CT_OC_MODE  = 0;  // 2 bits
  localparam int CT_ILIM     = 4;  // 4 bits
  localparam int CT_LOCK     = 8;  // 4 bits
  localparam int CT_EN       = 12; // 3 lock enables
  localparam int CT_UV_MODE  = 15;
  localparam int CT_CLR      = 16; // Write 1 to clear faults
  localparam int ST_DRV      = 0;
  localparam int ST_OC       = 1;
  localparam int ST_FET      = 2;  // 6 bits
  localparam int ST_CTL      = 8;
  localparam int ST_ILIM     = 9;
  localparam int ST_LOCK     = 10;
  localparam int ST_COND     = 11; // 3 bits
  localparam int ST_UV       = 14;
  localparam int ST_PIN      = 15;
  localparam int TH_EMF      = 16;
  localparam int T2_UVLO     = 16; // 3 bits
  localparam int T2_UVHI     = 20; // 3 bits
  localparam int DG_OC       = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST  = 32'hffff_ffff;
  localparam logic [31:0] THR2_RST = 32'h0000_0000;
  localparam logic [31:0] DEG_RST  = 32'h0000_0404;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MFRM_GATE_RUN = 2'b00,
    MFRM_GATE_HIZ = 2'b01,
    MFRM_GATE_HS  = 2'b10,
    MFRM_GATE_LS  = 2'b11
  } mfrm_gate_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mfrm_apb_req_t;

  typedef struct packed {
    logic        motor_running;
    logic [15:0] speed;
    logic [15:0] emf_diff;
    logic [35:0] phase_i;  // Three 12-bit phase currents
    logic [9:0]  supply_dv;
  } mfrm_sense_t;

endpackage

// ---- logic/mfrm_filt.sv ----
/*
 * Pin synchroniser with deglitch counter.
 * Assumes raw comes from outside the pclk domain.
 */
module mfrm_filt
  import mfrm_pkg::*;
#(
  parameter int CW = 8
)
(
  input  wire logic          pclk,    // Clock
  input  wire logic          presetn, // Async reset, low
  input  wire logic          raw,     // Asynchronous input
  input  wire logic [CW-1:0] deg,     // Deglitch in cycles
  output logic               level,   // Filtered level
  output logic               hit      // Held longer than deg
);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          s3;
    logic          lvl;
    logic [CW-1:0] cnt;
  } mfrm_filt_st_t;

  mfrm_filt_st_t st;
  mfrm_filt_st_t next_st;

  // ************************************************************
  // Sync, agree and count
  // ************************************************************
  always_comb
  begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Only the agreeing late stages may move the level
    if (st.s2 == st.s3)
      next_st.lvl = st.s3;
    if (!st.lvl)
      next_st.cnt = '0;
    else if (st.cnt != '1)
      next_st.cnt = st.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign level = st.lvl;
  assign hit   = st.lvl && (st.cnt > deg);

  AST_DEG_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !st.lvl |=> !hit) else $error("deglitch hit without level");
  AST_DEG_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hit) |-> st.cnt == deg + 1'b1 || deg == '1)
    else $error("deglitch fired at wrong count");

endmodule

// ---- logic/mfrm_core.sv ----
/*
 * Fault response manager: power stage overcurrent with retry, buck
 * overcurrent reset, hardware current limit, motor lock detectors and
 * supply undervoltage, all but the buck trip driving gate mode and the open-drain fault pin.
 * Assumes APB access, comparator outputs on pins and same-clock sense data.
 */
module mfrm_core
  import mfrm_pkg::*;
#(
  parameter int OC_RETRY  = OC_RETRY_CYC,
  parameter int LOCK_RETRY_TIME = LOCK_RETRY_TIME_CYC,
  parameter int OPEN_TIME = OPEN_PHASE_CYC
)
(
  input  wire logic          pclk,            // Clock, 100 MHz
  input  wire logic          presetn,         // Async reset, low
  input  wire mfrm_apb_req_t apb_req,         // APB request
  output logic [31:0]        prdata,          // APB read data
  output logic               pready,          // APB ready
  output logic               pslverr,         // APB error
  input  wire logic [5:0]    fet_overcurrent, // Per-transistor comparator
  input  wire logic          buck_overcurrent,// Buck high-side comparator
  input  wire logic          csa_over_limit,  // Current limit comparator
  input  wire mfrm_sense_t   sense,           // Same-clock sense data
  input  wire logic          fault_pin_n_in,  // Fault pin level
  output logic               fault_pin_n_out, // Fault pin drive value
  output logic               fault_pin_n_oe,  // Fault pin pulled low
  output mfrm_gate_t         gate_mode,       // Gate drive command
  output logic               buck_hiz,        // Buck switches off
  output logic               reset_req        // Device reset request
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] thr;
    logic [31:0] thr2;
    logic [31:0] deg;
    logic [31:0] rdata;
    logic        err;
    logic [5:0]  oc_fet;
    logic        oc_flag;
    logic        drv_fault;
    logic        oc_off;
    logic [31:0] oc_cnt;
    logic [1:0]  flag;      // 0 current limit, 1 motor lock
    logic [1:0]  act;
    logic [1:0]  autorec;
    logic [3:0]  act_code;
    logic [63:0] rcnt;
    logic [2:0]  cond;
    logic [31:0] open_cnt;
    logic        uv_flag;
    logic        buck_trip;
    logic        pin;
    mfrm_gate_t  gate;
  } mfrm_state_t;

  mfrm_state_t st;
  mfrm_state_t next_st;

  // ************************************************************
  // Pin filters
  // ************************************************************
  logic [8:0] raw_in;
  logic [8:0] f_lvl;
  logic [8:0] f_hit;
  logic [7:0] chan_deg [9];

  assign raw_in = {fault_pin_n_in, csa_over_limit, buck_overcurrent,
                   fet_overcurrent};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_filt
      // Transistors share one deglitch, others have their own
      if (gi < 6)
        assign chan_deg[gi] = st.deg[DG_OC +: 8];
      else if (gi == 6)
        assign chan_deg[gi] = 8'(BUCK_DEG_CYC);
      else if (gi == 7)
        assign chan_deg[gi] = st.deg[7:0];
      else
        assign chan_deg[gi] = 8'h00;
      mfrm_filt #(.CW(8)) u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (raw_in[gi]),
        .deg     (chan_deg[gi]),
        .level   (f_lvl[gi]),
        .hit     (f_hit[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Event detection
  // ************************************************************
  logic [1:0]  oc_mode;
  logic [3:0]  mode [2];
  logic [1:0]  ev;
  logic [2:0]  lc;
  logic        phase_low;
  logic        clr;
  logic [9:0]  uv_lvl;
  logic        uv_cond;
  logic        uv_ok;
  logic        wr_req;

  assign oc_mode = st.ctrl[CT_OC_MODE +: 2];
  assign mode[0] = st.ctrl[CT_ILIM +: 4];
  assign mode[1] = st.ctrl[CT_LOCK +: 4];
  assign wr_req  = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign clr     = wr_req && apb_req.paddr == ADDR_CTRL
                   && apb_req.pwdata[CT_CLR];

  // Any phase below threshold counts toward open phase
  always_comb
  begin
    phase_low = 1'b0;
    for (int p = 0; p < 3; p++)
      if (sense.phase_i[p*12 +: 12] < st.thr2[11:0])
        phase_low = 1'b1;
  end

  // Lock detectors only watch a running motor
  assign lc[0] = sense.motor_running && st.ctrl[CT_EN]
                 && sense.speed > st.thr[15:0];
  assign lc[1] = sense.motor_running && st.ctrl[CT_EN + 1]
                 && sense.emf_diff > st.thr[TH_EMF +: 16];
  assign lc[2] = st.ctrl[CT_EN + 2]
                 && st.open_cnt == OPEN_TIME;
  assign ev[0] = f_hit[7];
  assign ev[1] = |lc;

  // Trip level in 3.0 V steps per code; code zero disables the check
  assign uv_lvl  = 10'(st.thr2[T2_UVLO +: 3] * UV_STEP_DV);
  assign uv_cond = st.thr2[T2_UVLO +: 3] != 3'b000
                   && sense.supply_dv < uv_lvl;
  assign uv_ok   = sense.supply_dv > uv_lvl + 10'(UV_HYST_DV);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic       hard_off;
    logic       hs;
    logic       ls;
    logic [1:0] cd;
    hard_off = 1'b0;
    hs = 1'b0;
    ls = 1'b0;
    cd = 2'b00;
    next_st = st;

    // Register writes; clear-fault bit never stores
    if (wr_req)
    begin
      case (apb_req.paddr)
        ADDR_CTRL: next_st.ctrl = apb_req.pwdata & ~(32'h1 << CT_CLR);
        ADDR_THR:  next_st.thr  = apb_req.pwdata;
        ADDR_THR2: next_st.thr2 = apb_req.pwdata;
        ADDR_DEG:  next_st.deg  = apb_req.pwdata;
        default:   next_st.ctrl = st.ctrl;
      endcase
    end
    // Read data latched in setup phase so prdata comes from a flop
    if (apb_req.psel && !apb_req.penable)
    begin
      next_st.err   = 1'b0;
      next_st.rdata = '0;
      case (apb_req.paddr)
        ADDR_CTRL: next_st.rdata = st.ctrl;
        ADDR_THR:  next_st.rdata = st.thr;
        ADDR_THR2: next_st.rdata = st.thr2;
        ADDR_DEG:  next_st.rdata = st.deg;
        ADDR_STATUS:
        begin
          next_st.rdata[ST_DRV]      = st.drv_fault;
          next_st.rdata[ST_OC]       = st.oc_flag;
          next_st.rdata[ST_FET +: 6] = st.oc_fet;
          next_st.rdata[ST_CTL]      = |st.flag || st.uv_flag;
          next_st.rdata[ST_ILIM]     = st.flag[0];
          next_st.rdata[ST_LOCK]     = st.flag[1];
          next_st.rdata[ST_COND +: 3] = st.cond;
          next_st.rdata[ST_UV]       = st.uv_flag;
          next_st.rdata[ST_PIN]      = f_lvl[8];
        end
        default: next_st.err = 1'b1;
      endcase
    end

    // Open phase timer saturates at the 500 ms mark
    if (!(sense.motor_running && phase_low))
      next_st.open_cnt = '0;
    else if (st.open_cnt != OPEN_TIME)
      next_st.open_cnt = st.open_cnt + 1;

    // Power stage overcurrent: expiry, clear, then new event wins
    if (st.oc_cnt != 0)
    begin
      next_st.oc_cnt = st.oc_cnt - 1;
      if (st.oc_cnt == 1)
      begin
        next_st.oc_off    = 1'b0;
        next_st.drv_fault = 1'b0;
      end
    end
    if (clr && !(|f_lvl[5:0]))
    begin
      next_st.oc_flag = 1'b0;
      next_st.oc_fet  = '0;
      if (st.oc_cnt == 0)
      begin
        next_st.oc_off    = 1'b0;
        next_st.drv_fault = 1'b0;
      end
    end
    if (|f_hit[5:0] && oc_mode != 2'b11)
    begin
      next_st.oc_fet    = st.oc_fet | f_hit[5:0];
      next_st.oc_flag   = 1'b1;
      next_st.drv_fault = 1'b1;
      if (oc_mode == 2'b00)
      begin
        next_st.oc_off = 1'b1;
        next_st.oc_cnt = '0;
      end
      else if (oc_mode == 2'b01)
      begin
        next_st.oc_off = 1'b1;
        next_st.oc_cnt = 32'(OC_RETRY);
      end
    end

    // Current limit and motor lock share one response coding
    for (int k = 0; k < 2; k++)
    begin
      if (st.rcnt[k*32 +: 32] != 0)
      begin
        next_st.rcnt[k*32 +: 32] = st.rcnt[k*32 +: 32] - 1;
        if (st.rcnt[k*32 +: 32] == 1)
        begin
          next_st.act[k]     = 1'b0;
          next_st.flag[k]    = 1'b0;
          next_st.autorec[k] = 1'b0;
          if (k == 1)
            next_st.cond = 3'b000;
        end
      end
      // Clear only once the condition itself is gone
      if (clr && !ev[k] && !st.autorec[k])
      begin
        next_st.act[k]  = 1'b0;
        next_st.flag[k] = 1'b0;
        if (k == 1)
          next_st.cond = 3'b000;
      end
      if (ev[k] && !(mode[k][3] && mode[k][0]))
      begin
        next_st.flag[k] = 1'b1;
        if (k == 1)
          next_st.cond = st.cond | lc;
        if (!mode[k][3])
        begin
          next_st.act[k]           = 1'b1;
          next_st.act_code[k*2 +: 2] = mode[k][1:0];
          next_st.autorec[k]       = mode[k][2];
          next_st.rcnt[k*32 +: 32] = mode[k][2] ? 32'(LOCK_RETRY_TIME)
                                                : 32'h0000_0000;
        end
      end
    end

    // Supply undervoltage
    if (uv_cond)
      next_st.uv_flag = 1'b1;
    else if (st.ctrl[CT_UV_MODE] ? uv_ok : clr)
      next_st.uv_flag = 1'b0;

    // Buck overcurrent holds until device reset
    if (f_hit[6])
      next_st.buck_trip = 1'b1;

    // Gate mode: hard off beats any selected side drive
    hard_off = next_st.oc_off || next_st.uv_flag;
    for (int k = 0; k < 2; k++)
    begin
      cd = next_st.act_code[k*2 +: 2];
      if (next_st.act[k])
      begin
        if (cd[1] == 1'b0)
          hard_off = 1'b1;
        else if (cd[0])
          ls = 1'b1;
        else
          hs = 1'b1;
      end
    end
    if (hard_off || (hs && ls))
      next_st.gate = MFRM_GATE_HIZ;
    else if (hs)
      next_st.gate = MFRM_GATE_HS;
    else if (ls)
      next_st.gate = MFRM_GATE_LS;
    else
      next_st.gate = MFRM_GATE_RUN;
    next_st.pin = next_st.drv_fault || next_st.uv_flag
                  || |next_st.act;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st      <= '0;
      st.ctrl <= CTRL_RST;
      st.thr  <= THR_RST;
      st.thr2 <= THR2_RST;
      st.deg  <= DEG_RST;
    end
    else
      st <= next_st;
  end

  // Zero wait state slave
  assign pready          = 1'b1;
  assign pslverr         = apb_req.psel && apb_req.penable && st.err;
  assign prdata          = st.rdata;
  assign fault_pin_n_out = 1'b0;
  assign fault_pin_n_oe  = st.pin;
  assign gate_mode       = st.gate;
  assign buck_hiz        = st.buck_trip;
  assign reset_req       = st.buck_trip;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_oc_latch;
    |f_hit[5:0] && oc_mode == 2'b00;
  endsequence
  sequence s_oc_expire;
    st.oc_cnt == 1 && !(|f_hit[5:0]) && !clr;
  endsequence
  sequence s_lock_report;
    ev[1] && mode[1] == 4'b1000 && !st.act[1];
  endsequence

  AST_OC_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    s_oc_latch |=> gate_mode == MFRM_GATE_HIZ && fault_pin_n_oe
    && st.oc_flag) else $error("latched overcurrent not off");
  AST_OC_RETRY: assert property (@(posedge pclk) disable iff (!presetn)
    |f_hit[5:0] && oc_mode == 2'b01 |=> st.drv_fault
    && st.oc_cnt == OC_RETRY) else $error("retry not armed");
  AST_OC_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
    s_oc_expire |=> !st.drv_fault && st.oc_flag == $past(st.oc_flag))
    else $error("retry expiry wrong");
  AST_OC_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.oc_flag) |-> $past(clr)) else $error("flag lost");
  AST_LIM_HS: assert property (@(posedge pclk) disable iff (!presetn)
    ev[0] && mode[0] == 4'b0010 && !st.oc_off && !uv_cond && !st.uv_flag
    && !st.act[1] && !ev[1] && !(|f_hit[5:0])
    |=> gate_mode == MFRM_GATE_HS && fault_pin_n_oe)
    else $error("high side response missing");
  AST_LOCK_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
    ev[1] && mode[1][3] && mode[1][0] && !st.flag[1] |=> !st.flag[1])
    else $error("disabled lock reported");
  AST_LOCK_REPORT: assert property (@(posedge pclk) disable iff (!presetn)
    s_lock_report |=> st.flag[1] && !st.act[1])
    else $error("report-only acted");
  AST_UV_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    st.uv_flag && !st.ctrl[CT_UV_MODE] && !clr |=> st.uv_flag
    && gate_mode == MFRM_GATE_HIZ) else $error("undervoltage lost");
  AST_EN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    st.ctrl[CT_EN +: 3] == 3'b000 && !st.flag[1] |=> !st.flag[1])
    else $error("lock raised with detectors off");

endmodule

// ---- dv/mfrm_stage.sv ----
/*
 * Far-side model: power stage whose overcurrent stops while the bridge
 * is off, and the pulled-up fault pin wire shared with the host.
 * Assumes the bench requests overcurrent through oc_req.
 */
module mfrm_stage
  import mfrm_pkg::*;
(
  input  wire logic [5:0] oc_req, // Bench asks for overcurrent
  input  wire mfrm_gate_t gate,   // Gate command from the block
  input  wire logic       pin_oe, // Block pulls fault pin low
  input  wire logic       pin_dv, // Block's drive value
  output logic [5:0]      oc,     // Transistor comparators
  output logic            pin     // Fault pin wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Stage behaviour
  // ************************************************************
  // No current flows while the bridge is not driven
  assign oc = (gate == MFRM_GATE_RUN) ? oc_req : 6'h00;
  // Pull-up wins unless the block drives the wire
  assign pin = pin_oe ? pin_dv : 1'b1;
endmodule

// ---- dv/mfrm_core_tb_top.sv ----
/*
 * Self-checking bench of the fault response manager, one task a scenario.
 * Assumes short retry counts and the zero-wait APB slave.
 */
module mfrm_core_tb_top
  import mfrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OCR = 20;
  localparam int LKR = 30;
  logic          pclk;
  logic          presetn;
  mfrm_apb_req_t req;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [5:0]    oc_req;
  logic [5:0]    oc;
  logic          buck;
  logic          current_sense_amp;
  mfrm_sense_t   sense;
  logic          pin;
  logic          pin_oe;
  logic          pin_dv;
  mfrm_gate_t    gate;
  logic          buck_hiz;
  logic          reset_req;
  logic [31:0]   ctrl;
  int            num_errors;
  int            checks_done;

  // ************************************************************
  // Structure
  // ************************************************************
  mfrm_core #(.OC_RETRY(OCR), .LOCK_RETRY_TIME(LKR), .OPEN_TIME(40)) DUT (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fet_overcurrent(oc),
    .buck_overcurrent(buck), .csa_over_limit(current_sense_amp), .sense(sense),
    .fault_pin_n_in(pin), .fault_pin_n_out(pin_dv), .fault_pin_n_oe(pin_oe),
    .gate_mode(gate), .buck_hiz(buck_hiz), .reset_req(reset_req)
  );
  mfrm_stage STAGE (
    .oc_req(oc_req), .gate(gate), .pin_oe(pin_oe), .pin_dv(pin_dv),
    .oc(oc), .pin(pin)
  );
  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic go(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Sample away from the launching edge to avoid races
  task automatic look();
    @(negedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; waits on pready, bounded by the watchdog
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic r);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    r = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
                    input string nm);
    logic [31:0] q;
    logic        r;
    apb(1'b0, a, 32'h0000_0000, q, r);
    chk(nm, q & m, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        r;
    apb(1'b1, a, d, q, r);
  endtask
  task automatic setc(input logic [31:0] v);
    ctrl = v;
    wr(ADDR_CTRL, v);
  endtask
  // Clear pulse keeps the rest of the control word
  task automatic clr();
    wr(ADDR_CTRL, ctrl | (32'h0000_0001 << CT_CLR));
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [31:0] q;
    logic        r;
    rd(ADDR_CTRL, 32'hffff_ffff, CTRL_RST, "ctrl");
    rd(ADDR_THR, 32'hffff_ffff, THR_RST, "thr");
    rd(ADDR_THR2, 32'hffff_ffff, THR2_RST, "thr2");
    rd(ADDR_DEG, 32'hffff_ffff, DEG_RST, "deg");
    apb(1'b1, 12'h014, 32'h1234_5678, q, r);
    chk("unmapped", r, 32'h0000_0001);
    chk("ready", pready, 32'h0000_0001);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_STATUS, 32'hffff_ffff, 32'h0000_8000, "status");
  endtask
  // Latched then auto-retry overcurrent on one transistor
  task automatic t_oc();
    for (int md = 0; md < 2; md++)
    begin
      setc(32'(md));
      oc_req <= 6'h04;
      go(14);
      look();
      chk("oc gate", gate, MFRM_GATE_HIZ);
      chk("oc pin", pin, 32'h0);
      rd(ADDR_STATUS, 32'h13, 32'h13, "oc flags");
      oc_req <= 6'h00;
      go(OCR + 10);
      look();
      chk("oc after", gate, md[0] ? 2'b00 : 2'b01);
      chk("oc pin after", pin, md[0]);
      rd(ADDR_STATUS, 32'h13, md[0] ? 32'h12 : 32'h13, "oc kept");
      clr();
      rd(ADDR_STATUS, 32'h13, 32'h0, "oc clr");
      look();
      chk("oc run", gate, 2'b00);
    end
    // Report-only then disabled: the bridge keeps running
    for (int md = 2; md < 4; md++)
    begin
      setc(32'(md));
      oc_req <= 6'h04;
      go(14);
      look();
      chk("oc rep gate", gate, 2'b00);
      chk("oc rep pin", pin, md[0]);
      rd(ADDR_STATUS, 32'h13, md[0] ? 32'h0 : 32'h13, "oc rep");
      oc_req <= 6'h00;
      go(6);
      clr();
    end
  endtask
  // Every current-limit response code 0000 to 1001
  task automatic t_lim();
    logic [3:0]  c;
    logic [1:0]  g;
    logic [31:0] f;
    for (int i = 0; i < 10; i++)
    begin
      c = 4'(i);
      g = c[3] ? 2'b00 : (c[1] ? c[1:0] : 2'b01);
      f = (c == 4'h9) ? 32'h0 : 32'h0000_0300;
      setc(32'(c) << CT_ILIM);
      current_sense_amp <= 1'b1;
      go(14);
      look();
      chk("lim gate", gate, g);
      if (c != 4'h8)
        chk("lim pin", pin, c[3]);
      rd(ADDR_STATUS, 32'h300, f, "lim flags");
      current_sense_amp <= 1'b0;
      go(LKR + 10);
      look();
      chk("lim hold", gate, c[2] ? 2'b00 : g);
      rd(ADDR_STATUS, 32'h300, c[2] ? 32'h0 : f, "lim kept");
      clr();
      rd(ADDR_STATUS, 32'h300, 32'h0, "lim clr");
      look();
      chk("lim run", gate, 2'b00);
    end
  endtask
  // Overspeed ignored while disabled, latched once enabled
  task automatic t_lock();
    wr(ADDR_THR, 32'h0064_0064);
    setc(32'h0);
    sense.motor_running <= 1'b1;
    sense.speed <= 16'h00c8;
    go(14);
    look();
    chk("lock off", gate, 2'b00);
    rd(ADDR_STATUS, 32'h3d00, 32'h0, "lock off flags");
    setc(32'h0000_0001 << CT_EN);
    go(4);
    look();
    chk("lock gate", gate, 2'b01);
    rd(ADDR_STATUS, 32'hd00, 32'hd00, "lock flags");
    sense.speed <= 16'h0032;
    clr();
    rd(ADDR_STATUS, 32'hd00, 32'h0, "lock clr");
    // Report-only code flags without acting, then 1001 ignores it
    setc(32'h0000_1800);
    sense.speed <= 16'h00c8;
    go(4);
    look();
    chk("lock report", gate, 2'b00);
    rd(ADDR_STATUS, 32'hd00, 32'hd00, "lock rep flags");
    setc(32'h0000_1900);
    sense.speed <= 16'h0032;
    clr();
    sense.speed <= 16'h00c8;
    go(4);
    rd(ADDR_STATUS, 32'hd00, 32'h0, "lock ignored");
    // Back-EMF mismatch at once, open phase once its timer runs out
    sense.speed <= 16'h0032;
    wr(ADDR_THR2, 32'h0000_0010);
    setc(32'h0000_6000);
    sense.emf_diff <= 16'h00c8;
    go(50);
    look();
    chk("lock emf gate", gate, 2'b01);
    rd(ADDR_STATUS, 32'h3d00, 32'h3500, "lock emf open");
    sense.motor_running <= 1'b0;
    sense.emf_diff <= 16'h0000;
    clr();
    rd(ADDR_STATUS, 32'h3d00, 32'h0, "lock all clr");
    wr(ADDR_THR2, 32'h0000_0000);
  endtask
  // Undervoltage at 3.0 V, latched then self-clearing
  task automatic t_uv();
    wr(ADDR_THR2, 32'h0011_0000);
    for (int md = 0; md < 2; md++)
    begin
      setc(32'(md) << CT_UV_MODE);
      sense.supply_dv <= 10'h014;
      go(6);
      look();
      chk("uv gate", gate, 2'b01);
      go(1);
      sense.supply_dv <= 10'h021;
      go(8);
      look();
      chk("uv hyst", gate, 2'b01);
      go(1);
      sense.supply_dv <= 10'h024;
      go(8);
      look();
      chk("uv rise", gate, md[0] ? 2'b00 : 2'b01);
      clr();
      go(4);
      look();
      chk("uv clr", gate, 2'b00);
    end
    wr(ADDR_THR2, 32'h0000_0000);
  endtask
  // Latched overcurrent keeps the pin low after the limit recovers
  task automatic t_or();
    setc(32'h4 << CT_ILIM);
    oc_req <= 6'h01;
    current_sense_amp <= 1'b1;
    go(14);
    oc_req <= 6'h00;
    current_sense_amp <= 1'b0;
    go(LKR + 10);
    look();
    chk("or pin", pin, 32'h0);
    clr();
    go(4);
    look();
    chk("or pin clr", pin, 32'h1);
  endtask
  // Sticky, so it runs last
  task automatic t_buck();
    go(1);
    buck <= 1'b1;
    go(BUCK_DEG_CYC + 20);
    look();
    chk("buck hiz", buck_hiz, 32'h1);
    chk("buck reset", reset_req, 32'h1);
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence after a 20-cycle reset
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    oc_req = 6'h00;
    buck = 1'b0;
    current_sense_amp = 1'b0;
    sense = '0;
    sense.supply_dv = 10'h0c8;
    ctrl = 32'h0000_0000;
    num_errors = 0;
    checks_done = 0;
    go(20);
    presetn <= 1'b1;
    t_regs();
    t_oc();
    t_lim();
    t_lock();
    t_uv();
    t_or();
    t_buck();
    end_sim();
  end
  // Watchdog, well above the roughly 1300 cycles the run needs
  initial
  begin
    go(20000);
    num_errors++;
    end_sim();
  end
endmodule
